// ---- dram_link_if.sv ----
// Purpose: Command/address link between controller and DRAM end
// Assumes: Controller drives every signal; link clock made by divider
// Notes:   cmd, ma and op change only while ck is low; ba and row follow requests while idle
`timescale 1ns/1ps
interface dram_link_if;
    import dram_maint_pkg::*;
    logic        ck;
    cmd_t        cmd;
    logic [2:0]  ba;
    logic [15:0] row;
    logic [5:0]  ma;
    logic [7:0]  op;
    logic        devResetN;

    modport ctrl (output ck, cmd, ba, row, ma, op, devResetN);
    modport dram (input ck, cmd, ba, row, ma, op, devResetN);
endinterface

// ---- dram_maint_ctrl.sv ----
// Purpose: Controller end sequencing adjacent row refresh and fuse repair
// Assumes: Own clock makes the link clock; one command per link period
// Notes:   Waits start after the command slot, so spacing only grows
//
// Overview of operation
// - Enable bit one enables, zero disables refresh mode
// - Bank field selects target bank, others unchanged
// - Mode kept off during initialization and calibration
// - Enter from idle, no other mode writes
// - Device self-clears after third precharge plus delay
// - Exit write after completion ignores bank field
// - Three activates and precharges; precharge-all counts
// - Nothing before mode delay, then only activate/precharge
// - Other banks idle until 1.5 tRAS plus tRP
// - Precharge at 1.5 tRAS, reactivate tRP later
// - Second activate, precharge tRAS, third tRP later
// - Third precharge tRAS later; completion tRP plus tMRD
// - Abort: clear bit, three precharges tRP apart
// - No refresh or self refresh during mode
// - Mode activates skip refresh counter, restore victims
// - Normal timings apply; activates count in window
// - One fused row per bank; guard accidental entry
// - Precharge all, set repair bit, wait tMRD
// - Activate failing row, wait programming time
// - No command at all while programming
// - Wait exit time after precharge, clear bit
// - Wait settle time, reset device, reinitialise
`timescale 1ns/1ps
module dram_maint_ctrl
    import dram_maint_pkg::*;
#(
    parameter int PGM_CYC     = dram_maint_pkg::PROG_CYC,
    parameter int PGMPST_CYC  = dram_maint_pkg::SETTLE_CYC
)(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rstn,
    // Link to the memory
    dram_link_if.ctrl          link,
    // User requests
    input  wire logic          adjReq,
    input  wire logic          abortReq,
    input  wire logic          repairReq,
    input  wire logic          repairArm,
    input  wire logic          refReq,
    input  wire logic          calBusy,
    input  wire logic [2:0]    reqBank,
    input  wire logic [15:0]   reqRow,
    // User status
    output logic               busy,
    output logic               seqDone,
    output logic [7:0]         fuseUsed
);
    import dram_maint_pkg::*;

    if (PGM_CYC < 1 || PGMPST_CYC < 1 || LINK_DIV < 4)
    begin : g_chk
        $error("dram_maint_ctrl: bad timing parameter");
    end

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SEND = 3'b010,
        ST_WAIT = 3'b100
    } state_t;

    typedef enum logic [1:0] {
        SEQ_ADJ    = 2'h0,
        SEQ_ABORT  = 2'h1,
        SEQ_REPAIR = 2'h2,
        SEQ_REF    = 2'h3
    } seq_t;

    localparam int DW = $clog2(LINK_DIV);

    state_t      state_ff, nxt_state;
    seq_t        seq_ff, nxt_seq;
    logic [2:0]  step_ff, nxt_step;
    logic [31:0] timer_ff, nxt_timer;
    logic [DW-1:0] div_ff;
    logic        ck_ff;
    logic [2:0]  bank_ff, nxt_bank;
    logic [15:0] row_ff, nxt_row;
    logic [7:0]  fuse_ff, nxt_fuse;
    cmd_t        cmd_ff, nxt_cmd;
    logic [5:0]  ma_ff, nxt_ma;
    logic [7:0]  op_ff, nxt_op;
    logic        rst_ff, nxt_rst;
    logic        done_ff, nxt_done;

    // Current step of the active sequence
    cmd_t        stCmd;
    logic [5:0]  stMa;
    logic [7:0]  stOp;
    logic [31:0] stWait;
    logic        stLast;
    logic        stRst;
    logic        slotStart;

    // Free-running link clock divider
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            div_ff <= '0;
            ck_ff  <= 1'b0;
        end
        else
        begin
            div_ff <= div_ff + 1'b1;
            ck_ff  <= (div_ff >= DW'(LINK_DIV / 2 - 1)) &&
                      (div_ff != DW'(LINK_DIV - 1));
        end
    end

    assign slotStart = (div_ff == '0);

    always_comb
    begin
        stCmd  = CMD_NOP;
        stMa   = '0;
        stOp   = MR_RESET_VAL;
        stWait = 32'(TRP_CYC);
        stLast = 1'b0;
        stRst  = 1'b0;
        unique case (seq_ff)
            SEQ_ADJ:
                unique case (step_ff)
                    3'h0:
                    begin
                        stCmd  = CMD_MRW;
                        stMa   = MR_ROW_REFRESH;
                        stOp   = MR_RESET_VAL;
                        stOp[REF_EN_BIT] = 1'b1;
                        stOp[BANK_LSB +: 3] = bank_ff;
                        stWait = 32'(TMRD_CYC);
                    end
                    3'h1:
                    begin
                        stCmd  = CMD_ACT;
                        stWait = 32'(TRAS15_CYC);
                    end
                    3'h3, 3'h5:
                    begin
                        stCmd  = CMD_ACT;
                        stWait = 32'(TRAS_CYC);
                    end
                    3'h6:
                    begin
                        stCmd  = CMD_PRE;
                        stWait = 32'(TRP_CYC + TMRD_CYC);
                        stLast = 1'b1;
                    end
                    default:
                        stCmd  = CMD_PRE;
                endcase
            SEQ_ABORT:
            begin
                stCmd  = (step_ff == 3'h0) ? CMD_MRW : CMD_PRE;
                stMa   = MR_ROW_REFRESH;
                stWait = (step_ff == 3'h0) ? 32'(TMRD_CYC) :
                                             32'(TRP_CYC);
                stLast = (step_ff == 3'h3);
            end
            SEQ_REPAIR:
                unique case (step_ff)
                    3'h0:
                        stCmd  = CMD_PREA;
                    3'h1:
                    begin
                        stCmd  = CMD_MRW;
                        stMa   = MR_REPAIR;
                        stOp[REPAIR_EN_BIT] = 1'b1;
                        stWait = 32'(TMRD_CYC);
                    end
                    3'h2:
                    begin
                        stCmd  = CMD_ACT;
                        stWait = 32'(PGM_CYC);
                    end
                    3'h3:
                    begin
                        stCmd  = CMD_PRE;
                        stWait = 32'(TEXIT_CYC);
                    end
                    3'h4:
                    begin
                        stCmd  = CMD_MRW;
                        stMa   = MR_REPAIR;
                        stWait = 32'(PGMPST_CYC);
                    end
                    default:
                    begin
                        stRst  = 1'b1;
                        stWait = 32'(TPW_CYC);
                        stLast = 1'b1;
                    end
                endcase
            SEQ_REF:
            begin
                stCmd  = CMD_REF;
                stLast = 1'b1;
            end
        endcase
    end

    always_comb
    begin
        nxt_state = state_ff;
        nxt_seq   = seq_ff;
        nxt_step  = step_ff;
        nxt_timer = timer_ff;
        nxt_bank  = bank_ff;
        nxt_row   = row_ff;
        nxt_fuse  = fuse_ff;
        nxt_cmd   = cmd_ff;
        nxt_ma    = ma_ff;
        nxt_op    = op_ff;
        nxt_rst   = rst_ff;
        nxt_done  = 1'b0;
        // Commands last exactly one link period
        if (slotStart)
            nxt_cmd = CMD_NOP;
        unique case (state_ff)
            ST_IDLE:
            begin
                nxt_step = '0;
                nxt_bank = reqBank;
                nxt_row  = reqRow;
                // Refresh only from idle, never inside a sequence
                if (refReq)
                begin
                    nxt_seq   = SEQ_REF;
                    nxt_state = ST_SEND;
                end
                else if (adjReq && !calBusy)
                begin
                    nxt_seq   = SEQ_ADJ;
                    nxt_state = ST_SEND;
                end
                else if (abortReq)
                begin
                    nxt_seq   = SEQ_ABORT;
                    nxt_state = ST_SEND;
                end
                // Fuses are permanent: need arm level and a free bank
                else if (repairReq && repairArm &&
                         !fuse_ff[reqBank])
                begin
                    nxt_seq   = SEQ_REPAIR;
                    nxt_state = ST_SEND;
                end
            end
            ST_SEND:
                if (slotStart)
                begin
                    nxt_cmd   = stCmd;
                    nxt_ma    = stMa;
                    nxt_op    = stOp;
                    nxt_rst   = stRst;
                    nxt_timer = 32'(LINK_DIV) + stWait;
                    nxt_state = ST_WAIT;
                end
            ST_WAIT:
                if (timer_ff > 32'h1)
                    nxt_timer = timer_ff - 32'h1;
                else
                begin
                    nxt_rst = 1'b0;
                    if (stLast)
                    begin
                        if (seq_ff == SEQ_REPAIR)
                            nxt_fuse[bank_ff] = 1'b1;
                        nxt_done  = 1'b1;
                        nxt_state = ST_IDLE;
                    end
                    else
                    begin
                        nxt_step  = step_ff + 3'h1;
                        nxt_state = ST_SEND;
                    end
                end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_ff <= ST_IDLE;
            seq_ff   <= SEQ_ADJ;
            step_ff  <= '0;
            timer_ff <= '0;
            bank_ff  <= '0;
            row_ff   <= '0;
            fuse_ff  <= '0;
            cmd_ff   <= CMD_NOP;
            ma_ff    <= '0;
            op_ff    <= '0;
            rst_ff   <= 1'b0;
            done_ff  <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            seq_ff   <= nxt_seq;
            step_ff  <= nxt_step;
            timer_ff <= nxt_timer;
            bank_ff  <= nxt_bank;
            row_ff   <= nxt_row;
            fuse_ff  <= nxt_fuse;
            cmd_ff   <= nxt_cmd;
            ma_ff    <= nxt_ma;
            op_ff    <= nxt_op;
            rst_ff   <= nxt_rst;
            done_ff  <= nxt_done;
        end
    end

    assign link.ck        = ck_ff;
    assign link.cmd       = cmd_ff;
    assign link.ba        = bank_ff;
    assign link.row       = row_ff;
    assign link.ma        = ma_ff;
    assign link.op        = op_ff;
    assign link.devResetN = !rst_ff;
    assign busy           = (state_ff != ST_IDLE);
    assign seqDone        = done_ff;
    assign fuseUsed       = fuse_ff;
endmodule

// ---- dram_maint_dev.sv ----
// Purpose: DRAM end tracking adjacent row refresh and fuse repair
// Assumes: Link fields settle well before each link clock rise
// Notes:   Fuse map survives link reset, cleared only by rstn
`timescale 1ns/1ps
module dram_maint_dev
    import dram_maint_pkg::*;
#(
    parameter int PGM_CYC = dram_maint_pkg::PROG_CYC
)(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rstn,
    // Link from the controller
    dram_link_if.dram          link,
    // Status
    output logic               adjActive,
    output logic [2:0]         adjBank,
    output logic               repairActive,
    output logic [7:0]         fuseMap,
    // Events
    output logic               restorePulse,
    output logic [15:0]        restoreRow,
    output logic               refreshAdvance,
    output logic               illegalCmd
);
    import dram_maint_pkg::*;

    if (PGM_CYC < 1)
    begin : g_chk
        $error("dram_maint_dev: bad programming time");
    end

    localparam int SW = 38;
    localparam logic [15:0] DONE_CYC = 16'(TRP_CYC + TMRD_CYC);

    logic [SW-1:0] sync1_ff, sync2_ff;
    logic          ckPrev_ff;
    logic          rise;
    logic          lkReset;
    cmd_t          cmd;
    logic [2:0]    ba;
    logic [15:0]   row;
    logic [5:0]    ma;
    logic [7:0]    op;

    logic [7:0]  rowRef_ff, nxt_rowRef;
    logic [7:0]  repair_ff, nxt_repair;
    logic [1:0]  actCnt_ff, nxt_actCnt;
    logic [1:0]  preCnt_ff, nxt_preCnt;
    logic [15:0] doneTmr_ff, nxt_doneTmr;
    logic [15:0] tgtRow_ff, nxt_tgtRow;
    logic        pgm_ff, nxt_pgm;
    logic [2:0]  pgmBank_ff, nxt_pgmBank;
    logic [31:0] pgmTmr_ff, nxt_pgmTmr;
    logic [7:0]  fuse_ff, nxt_fuse;
    logic        restore_ff, nxt_restore;
    logic        refAdv_ff, nxt_refAdv;
    logic        illegal_ff, nxt_illegal;
    logic        isPre;
    logic        onBank;

    // All link pins pass two flip-flops
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sync1_ff  <= '0;
            sync2_ff  <= '0;
            ckPrev_ff <= 1'b0;
        end
        else
        begin
            sync1_ff  <= {link.ck, link.devResetN, link.cmd, link.ba,
                          link.row, link.ma, link.op};
            sync2_ff  <= sync1_ff;
            ckPrev_ff <= sync2_ff[SW-1];
        end
    end

    assign rise    = sync2_ff[SW-1] && !ckPrev_ff;
    assign lkReset = !sync2_ff[SW-2];
    assign cmd     = cmd_t'(sync2_ff[35:33]);
    assign ba      = sync2_ff[32:30];
    assign row     = sync2_ff[29:14];
    assign ma      = sync2_ff[13:8];
    assign op      = sync2_ff[7:0];
    assign onBank  = (ba == rowRef_ff[BANK_LSB +: 3]);
    assign isPre   = (cmd == CMD_PREA) || (cmd == CMD_PRE && onBank);

    always_comb
    begin
        nxt_rowRef  = rowRef_ff;
        nxt_repair  = repair_ff;
        nxt_actCnt  = actCnt_ff;
        nxt_preCnt  = preCnt_ff;
        nxt_doneTmr = doneTmr_ff;
        nxt_tgtRow  = tgtRow_ff;
        nxt_pgm     = pgm_ff;
        nxt_pgmBank = pgmBank_ff;
        nxt_pgmTmr  = pgmTmr_ff;
        nxt_fuse    = fuse_ff;
        nxt_restore = 1'b0;
        nxt_refAdv  = 1'b0;
        nxt_illegal = 1'b0;
        if (pgm_ff && pgmTmr_ff != 32'hffffffff)
            nxt_pgmTmr = pgmTmr_ff + 32'h1;
        // Self-clear once the post-precharge delay runs out
        if (doneTmr_ff != '0)
        begin
            nxt_doneTmr = doneTmr_ff - 16'h1;
            if (doneTmr_ff == 16'h1)
            begin
                nxt_rowRef[REF_EN_BIT] = 1'b0;
                nxt_restore = 1'b1;
            end
        end
        if (lkReset)
        begin
            nxt_rowRef  = MR_RESET_VAL;
            nxt_repair  = MR_RESET_VAL;
            nxt_actCnt  = '0;
            nxt_preCnt  = '0;
            nxt_doneTmr = '0;
            nxt_pgm     = 1'b0;
        end
        else if (rise)
            unique case (cmd)
                CMD_MRW:
                    if (ma == MR_ROW_REFRESH)
                    begin
                        nxt_actCnt  = '0;
                        nxt_preCnt  = '0;
                        nxt_doneTmr = '0;
                        if (op[REF_EN_BIT])
                            nxt_rowRef = op;
                        else
                            nxt_rowRef[REF_EN_BIT] = 1'b0;
                    end
                    else if (ma == MR_REPAIR)
                        nxt_repair = op;
                CMD_ACT:
                begin
                    if (rowRef_ff[REF_EN_BIT] && onBank &&
                        actCnt_ff != ADJ_STEPS)
                    begin
                        nxt_actCnt = actCnt_ff + 2'h1;
                        if (actCnt_ff == '0)
                            nxt_tgtRow = row;
                    end
                    // One row at a time: activates are ignored while a row is programming
                    if (repair_ff[REPAIR_EN_BIT] && !pgm_ff)
                    begin
                        nxt_pgm     = 1'b1;
                        nxt_pgmBank = ba;
                        nxt_pgmTmr  = '0;
                    end
                end
                CMD_PRE, CMD_PREA:
                begin
                    if (rowRef_ff[REF_EN_BIT] && isPre &&
                        preCnt_ff < actCnt_ff)
                    begin
                        nxt_preCnt = preCnt_ff + 2'h1;
                        if (preCnt_ff == ADJ_STEPS - 2'h1)
                            nxt_doneTmr = DONE_CYC;
                    end
                    if (pgm_ff && (cmd == CMD_PREA || ba == pgmBank_ff))
                    begin
                        nxt_pgm = 1'b0;
                        // Too short a program time leaves the fuse intact
                        if (pgmTmr_ff >= 32'(PGM_CYC))
                            nxt_fuse[pgmBank_ff] = 1'b1;
                    end
                end
                CMD_REF:
                    if (rowRef_ff[REF_EN_BIT])
                        nxt_illegal = 1'b1;
                    else
                        nxt_refAdv = 1'b1;
                CMD_SRE:
                    nxt_illegal = rowRef_ff[REF_EN_BIT];
                default:
                    ;
            endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rowRef_ff  <= MR_RESET_VAL;
            repair_ff  <= MR_RESET_VAL;
            actCnt_ff  <= '0;
            preCnt_ff  <= '0;
            doneTmr_ff <= '0;
            tgtRow_ff  <= '0;
            pgm_ff     <= 1'b0;
            pgmBank_ff <= '0;
            pgmTmr_ff  <= '0;
            fuse_ff    <= '0;
            restore_ff <= 1'b0;
            refAdv_ff  <= 1'b0;
            illegal_ff <= 1'b0;
        end
        else
        begin
            rowRef_ff  <= nxt_rowRef;
            repair_ff  <= nxt_repair;
            actCnt_ff  <= nxt_actCnt;
            preCnt_ff  <= nxt_preCnt;
            doneTmr_ff <= nxt_doneTmr;
            tgtRow_ff  <= nxt_tgtRow;
            pgm_ff     <= nxt_pgm;
            pgmBank_ff <= nxt_pgmBank;
            pgmTmr_ff  <= nxt_pgmTmr;
            fuse_ff    <= nxt_fuse;
            restore_ff <= nxt_restore;
            refAdv_ff  <= nxt_refAdv;
            illegal_ff <= nxt_illegal;
        end
    end

    assign adjActive      = rowRef_ff[REF_EN_BIT];
    assign adjBank        = rowRef_ff[BANK_LSB +: 3];
    assign repairActive   = repair_ff[REPAIR_EN_BIT];
    assign fuseMap        = fuse_ff;
    assign restorePulse   = restore_ff;
    assign restoreRow     = tgtRow_ff;
    assign refreshAdvance = refAdv_ff;
    assign illegalCmd     = illegal_ff;
endmodule

// ---- dram_maint_pkg.sv ----
// Purpose: Shared constants and types for the DRAM maintenance link
// Assumes: 200 MHz system clock on both ends
// Notes:   Cycle counts round least times up to whole cycles
package dram_maint_pkg;

    localparam int CLK_MHZ      = 200;
    localparam int LINK_DIV     = 32;

    // Core timings, plain defaults
    localparam int TRAS_NS      = 42;
    localparam int TRP_NS       = 18;
    localparam int TMRD_NS      = 14;
    localparam int TPW_RESET_NS = 200;

    // Repair timings
    localparam int PROG_MS      = 1000;
    localparam int PROG_EXIT_NS = 15;
    localparam int SETTLE_US    = 50;

    localparam int TRAS_CYC     = (TRAS_NS * CLK_MHZ + 999) / 1000;
    localparam int TRAS15_CYC   = (3 * TRAS_NS * CLK_MHZ + 1999) / 2000;
    localparam int TRP_CYC      = (TRP_NS * CLK_MHZ + 999) / 1000;
    localparam int TMRD_CYC     = (TMRD_NS * CLK_MHZ + 999) / 1000;
    localparam int TPW_CYC      = (TPW_RESET_NS * CLK_MHZ + 999) / 1000;
    localparam int TEXIT_CYC    = (PROG_EXIT_NS * CLK_MHZ + 999) / 1000;
    localparam int PROG_CYC     = PROG_MS * 1000 * CLK_MHZ;
    localparam int SETTLE_CYC   = SETTLE_US * CLK_MHZ;

    // Mode register addresses and fields
    localparam logic [5:0] MR_ROW_REFRESH = 6'h18;
    localparam logic [5:0] MR_REPAIR      = 6'h04;
    localparam int         REF_EN_BIT     = 7;
    localparam int         BANK_LSB       = 4;
    localparam int         REPAIR_EN_BIT  = 4;
    localparam logic [7:0] MR_RESET_VAL   = 8'h00;
    localparam logic [1:0] ADJ_STEPS      = 2'h3;

    typedef enum logic [2:0] {
        CMD_NOP  = 3'h0,
        CMD_MRW  = 3'h1,
        CMD_ACT  = 3'h2,
        CMD_PRE  = 3'h3,
        CMD_PREA = 3'h4,
        CMD_REF  = 3'h5,
        CMD_SRE  = 3'h6
    } cmd_t;

endpackage

// ---- dram_row_refresh_repair_seq_monitor.sv ----
// Purpose: Link checks for adjacent row refresh and repair
// Assumes: One clk domain, rstn synchronous low
// Notes:   Mode is tracked from link commands only
`timescale 1ns/1ps
module dram_row_refresh_repair_seq_monitor (
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 rstn,
    // Link
    input wire logic                 ck,
    input wire dram_maint_pkg::cmd_t cmd,
    input wire logic [2:0]           ba,
    input wire logic [5:0]           ma,
    input wire logic [7:0]           op
);
    import dram_maint_pkg::*;
    cmd_t       prevCmd;
    logic       refMode;
    logic [2:0] modeBank;
    logic [1:0] preCnt;
    wire        newCmd = (cmd != prevCmd);
    wire        isPre = newCmd && (cmd == CMD_PRE || cmd == CMD_PREA);

    // Any other write ends the mode, so repair entry clears it too
    always_ff @(posedge clk)
    begin
        prevCmd <= cmd;
        if (!rstn || (newCmd && cmd == CMD_MRW))
        begin
            refMode  <= rstn && ma == MR_ROW_REFRESH && op[REF_EN_BIT];
            modeBank <= op[BANK_LSB +: 3];
            preCnt   <= 2'h0;
        end
        else if (refMode && isPre)
        begin
            preCnt  <= preCnt + 2'h1;
            refMode <= (preCnt != 2'h2);
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_ref_outside: assert property (
        cmd inside {CMD_REF, CMD_SRE} |-> !refMode) else $error("ref in mode");
    a_act_bank: assert property (
        cmd == CMD_ACT && refMode |-> ba == modeBank) else $error("act bank");
    a_pre_bank: assert property (
        cmd == CMD_PRE && refMode |-> ba == modeBank) else $error("pre bank");
    a_enter_idle: assert property (
        newCmd && cmd == CMD_MRW && ma == MR_ROW_REFRESH && op[REF_EN_BIT]
        |-> !refMode && $past(cmd) == CMD_NOP) else $error("entry not idle");
    a_mrd_quiet: assert property (
        $fell(cmd == CMD_MRW) && refMode |-> (cmd == CMD_NOP)[*3])
        else $error("command inside mode delay");
    a_cmd_hold: assert property (
        $changed(cmd) |=> $stable(cmd)[*8]) else $error("command not held");
    a_ck_low_change: assert property (
        $changed(cmd) |-> !ck) else $error("command moved while ck high");
    a_pgm_quiet: assert property (
        $fell(cmd == CMD_ACT) && !refMode |-> (cmd == CMD_NOP)[*8])
        else $error("command while programming");
endmodule

// ---- dram_row_refresh_repair_seq_tb.sv ----
// Purpose: Both ends joined; refresh, abort, refuse and repair runs
// Assumes: Short repair counts, dev count not above ctrl count
// Notes:   No faulty far end is modelled, for size
`timescale 1ns/1ps
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin \
    failures++; $display("wrong value %0t %h %h", $time, a, b); end end
module dram_row_refresh_repair_seq_tb;
    import dram_maint_pkg::*;
    logic        clk, rstn, adjReq, abortReq, repairReq, repairArm, refReq;
    logic        calBusy, busy, seqDone, adjActive, repairActive;
    logic        restorePulse, refreshAdvance, illegalCmd;
    logic [2:0]  reqBank, adjBank, actBank;
    logic [7:0]  fuseUsed, fuseMap;
    logic [15:0] reqRow, restoreRow, lastRow;
    int          failures, samplesChecked, n, cnt[5];
    dram_link_if link ();
    dram_maint_ctrl #(.PGM_CYC(50), .PGMPST_CYC(40)) dram_maint_ctrl_i (
        .clk, .rstn, .link, .adjReq, .abortReq, .repairReq, .repairArm,
        .refReq, .calBusy, .reqBank, .reqRow, .busy, .seqDone, .fuseUsed);
    dram_maint_dev #(.PGM_CYC(50)) dram_maint_dev_i (
        .clk, .rstn, .link, .adjActive, .adjBank, .repairActive, .fuseMap,
        .restorePulse, .restoreRow, .refreshAdvance, .illegalCmd);
    dram_row_refresh_repair_seq_monitor dram_row_refresh_repair_seq_monitor_i (
        .clk, .rstn, .ck(link.ck), .cmd(link.cmd), .ba(link.ba),
        .ma(link.ma), .op(link.op));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic reportAndStop;
        $display("checks %0d failures %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Drops requests once taken, tallies device events until done
    task automatic runSeq;
        @(posedge clk);
        {adjReq, abortReq, repairReq, refReq} <= 4'h0;
        cnt = '{default: 0};
        for (n = 0; n < 5000 && seqDone !== 1'b1; n++)
        begin
            @(posedge clk);
            cnt[0] += (restorePulse === 1'b1);
            cnt[1] += (refreshAdvance === 1'b1);
            cnt[2] += (illegalCmd === 1'b1);
            cnt[4] += (repairActive === 1'b1);
            if (restorePulse === 1'b1) lastRow = restoreRow;
            if (adjActive === 1'b1) cnt[3]++;
            if (adjActive === 1'b1) actBank = adjBank;
        end
        if (n == 5000)
        begin
            failures++;
            reportAndStop();
        end
    endtask

    task automatic adjRun(input logic [2:0] bank, input logic [15:0] r);
        @(posedge clk);
        reqBank <= bank;
        reqRow <= r;
        adjReq <= 1'b1;
        runSeq();
        `CHK(actBank, bank)
        `CHK(cnt[3] > 0, 1'b1)
        `CHK(cnt[0], 1)
        `CHK(lastRow, r)
        `CHK(cnt[1] + cnt[2], 0)
        `CHK(adjActive, 1'b0)
    endtask

    task automatic oneRun(input int which);
        @(posedge clk);
        if (which == 0) refReq <= 1'b1;
        else abortReq <= 1'b1;
        runSeq();
        `CHK(cnt[1], 1 - which)
        `CHK(cnt[0] + cnt[3], 0)
    endtask

    task automatic refuseRun(input logic [2:0] bank, input logic arm);
        @(posedge clk);
        reqBank <= bank;
        repairArm <= arm;
        calBusy <= 1'b1;
        {adjReq, repairReq} <= 2'h3;
        repeat (6) @(posedge clk);
        `CHK(busy, 1'b0)
        {adjReq, repairReq, calBusy} <= 3'h0;
    endtask

    initial
    begin
        {rstn, adjReq, abortReq, repairReq, repairArm, refReq, calBusy} = '0;
        {reqBank, reqRow, failures, samplesChecked} = '0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        oneRun(0);
        adjRun(3'h0, 16'hffff);
        adjRun(3'h7, 16'h0001);
        oneRun(1);
        `CHK(adjBank, 3'h7)
        @(posedge clk);
        reqBank <= 3'h2;
        repairArm <= 1'b1;
        repairReq <= 1'b1;
        runSeq();
        `CHK(cnt[4] > 0, 1'b1)
        `CHK(fuseUsed[2], 1'b1)
        refuseRun(3'h2, 1'b1);
        refuseRun(3'h3, 1'b0);
        `CHK(fuseMap, 8'h04)
        reportAndStop();
    end
endmodule
